/* rtl/rsc_pkg.sv */
// Shared constants and types for the relay switch control port
package rsc_pkg;

    // Frame and register geometry
    localparam int FRAME_BITS      = 16;
    localparam int REG_BITS        = 8;
    localparam int CHANNELS        = 6;
    localparam int SYNC_STAGES     = 2;
    localparam int IDX_BITS        = 5;

    // Field positions inside the 16-bit serial word
    localparam int WORD_ARM_POS    = 15;
    localparam int WORD_CTRL_MSB   = 15;
    localparam int WORD_CTRL_LSB   = 8;
    localparam int WORD_STATE_MSB  = 7;
    localparam int WORD_STATE_LSB  = 0;

    // Control register bit positions
    localparam int CTRL_ARM_POS    = 7;
    localparam int CTRL_FAULT_POS  = 6;
    localparam int CTRL_AOFF_POS   = 5;
    localparam int CTRL_FSD_POS    = 4;
    localparam int CTRL_UVC_POS    = 3;
    localparam int CTRL_PUMP_POS   = 1;

    // Reset values
    localparam logic [7:0] STATE_RST = 8'h00;
    localparam logic [7:0] CTRL_RST  = 8'h00;

    // Link clock ceiling in MHz, kept by the host
    localparam int LINK_MAX_MHZ    = 33;

    // Index saturation value for the outgoing bit counter
    localparam logic [IDX_BITS-1:0] IDX_SAT = 5'h10;

    // Control register layout, bit 7 first
    typedef struct packed {
        logic write_arm;
        logic fault_sticky;
        logic analog_off;
        logic fault_shutdown_off;
        logic pp_uv_cmp_off;
        logic spare_2;
        logic pump_on;
        logic spare_0;
    } rsc_ctrl_t;

    // Whole serial word: control byte above switch state byte
    typedef struct packed {
        rsc_ctrl_t  ctrl;
        logic [7:0] state;
    } rsc_word_t;

endpackage

/* rtl/rsc_gpio_map.sv */
// Parallel-mode decoder from four select lines to six switch closures
`timescale 1ns/10ps
`default_nettype none
module rsc_gpio_map
    import rsc_pkg::*;
(
    input  wire logic       MAP_SELECT,     // Mapping choice
    input  wire logic [3:0] SEL_IN,         // sel_in_4..sel_in_1
    output logic      [5:0] SWITCH_CLOSE    // switch_6..switch_1
);

    logic [2:0] code;

    // Decode select lines into switch closures
    always_comb begin
        code = SEL_IN[2:0];
        SWITCH_CLOSE = 6'h00;
        if (!MAP_SELECT) begin
            // Direct map with paired channels
            SWITCH_CLOSE[0] = SEL_IN[0];
            SWITCH_CLOSE[1] = SEL_IN[1];
            SWITCH_CLOSE[2] = SEL_IN[2];
            SWITCH_CLOSE[5] = SEL_IN[2];
            SWITCH_CLOSE[3] = SEL_IN[3];
            SWITCH_CLOSE[4] = SEL_IN[3];
        end else if (!SEL_IN[3]) begin
            // One-of-six selection
            unique case (code)
                3'h1: SWITCH_CLOSE = 6'h01;
                3'h2: SWITCH_CLOSE = 6'h02;
                3'h3: SWITCH_CLOSE = 6'h04;
                3'h4: SWITCH_CLOSE = 6'h08;
                3'h5: SWITCH_CLOSE = 6'h10;
                3'h6: SWITCH_CLOSE = 6'h20;
                default: SWITCH_CLOSE = 6'h00;
            endcase
        end else begin
            // Three-switch path patterns
            unique case (code)
                3'h1: SWITCH_CLOSE = 6'h29;
                3'h2: SWITCH_CLOSE = 6'h26;
                3'h3: SWITCH_CLOSE = 6'h1A;
                3'h4: SWITCH_CLOSE = 6'h2A;
                3'h5: SWITCH_CLOSE = 6'h2A;
                3'h6: SWITCH_CLOSE = 6'h15;
                default: SWITCH_CLOSE = 6'h00;
            endcase
        end
    end

endmodule // rsc_gpio_map
`default_nettype wire

/* rtl/rsc_top.sv */
// Relay switch control port: serial target, parallel decode, fault control
`timescale 1ns/10ps
`default_nettype none
module rsc_top
    import rsc_pkg::*;
(
    input  wire logic       CLK_SYS,            // System clock, 125 MHz
    input  wire logic       NRST,               // Async reset, active low
    input  wire logic       CE,                 // Clock enable for system domain
    input  wire logic       MODE,               // Low serial, high parallel
    input  wire logic       SCK,                // Serial link clock
    input  wire logic       MOSI,               // Serial data in
    input  wire logic       SELECT_N,           // Frame select, active low
    output logic            MISO_O,             // Serial data out value
    output logic            MISO_OE,            // Serial data out enable
    input  wire logic [3:0] SEL_IN,             // Same four pins as levels
    input  wire logic       MAP_SELECT,         // Parallel mapping choice
    input  wire logic       PUMP_ENABLE_PIN,    // Pump enable, parallel mode
    input  wire logic       FAULT_SHUTDOWN_PIN, // High disables shutdown, parallel
    input  wire logic       VDD_UV,             // Core supply under-voltage
    input  wire logic       VPP_UV,             // High-voltage supply under-voltage
    output logic      [5:0] SWITCH_CLOSE,       // switch_6..switch_1 closures
    output logic            PUMP_ENABLE,        // Charge pump run
    output logic            ANALOG_ENABLE,      // Analog circuits on
    output logic            VPP_CMP_ENABLE,     // VPP comparator on
    output logic            FAULT_OUT_N_O,      // Open-drain fault value
    output logic            FAULT_OUT_N_OE,     // Open-drain fault pull-down
    output logic      [7:0] STATE_VIEW,         // Switch state register
    output logic      [7:0] CTRL_VIEW           // Control register
);

    localparam int NSYNC = 12;

    // Synchronised pin levels, system domain
    logic [NSYNC-1:0] pin_raw;
    logic [NSYNC-1:0] sync1_ff;
    logic [NSYNC-1:0] sync2_ff;
    logic             mode_par;
    logic             sel_n_s;
    logic             map_s;
    logic [3:0]       sel_s;
    logic             pump_pin_s;
    logic             fsd_pin_s;
    logic             vdd_uv_s;
    logic             vpp_uv_s;

    // Registers and control state
    logic [7:0]       state_ff;
    rsc_ctrl_t        ctrl_ff;
    logic [7:0]       nxt_state;
    rsc_ctrl_t        nxt_ctrl;
    logic             sel_n_d_ff;
    logic             held_open;
    logic             sel_rise;
    logic             cap_valid_ff;
    rsc_word_t        word_cap_ff;

    // Shutdown sequence: running, tripped, waiting for the pump to return
    typedef enum logic [2:0] {
        SD_RUN  = 3'b001,
        SD_TRIP = 3'b010,
        SD_WAIT = 3'b100
    } rsc_sd_t;
    rsc_sd_t          sd_ff;
    rsc_sd_t          nxt_sd;
    rsc_word_t        tx_word_ff;
    logic             commit;
    logic             fault_now;
    logic             vpp_watch;
    logic             shutdown_en;
    logic             pump_src;
    logic [5:0]       gpio_close;

    // Link domain state
    logic [FRAME_BITS-1:0] rx_ff;
    logic [IDX_BITS-1:0]   idx_ff;
    logic [IDX_BITS-1:0]   nxt_idx;
    logic                  miso_ff;
    logic                  frame_idle;

    // Pin bundle for the synchronisers
    assign pin_raw = {SELECT_N, MODE, MAP_SELECT, SEL_IN, PUMP_ENABLE_PIN,
                      FAULT_SHUTDOWN_PIN, VDD_UV, VPP_UV, 1'b0};

    // Two-stage synchroniser per pin bit
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge CLK_SYS or negedge NRST) begin
                if (!NRST) begin
                    sync1_ff[gi] <= 1'b0;
                    sync2_ff[gi] <= 1'b0;
                end else if (CE) begin
                    sync1_ff[gi] <= pin_raw[gi];
                    sync2_ff[gi] <= sync1_ff[gi];
                end
            end
        end
    endgenerate

    // Unpack synchronised levels
    assign sel_n_s    = sync2_ff[11];
    assign mode_par   = sync2_ff[10];
    assign map_s      = sync2_ff[9];
    assign sel_s      = sync2_ff[8:5];
    assign pump_pin_s = sync2_ff[4];
    assign fsd_pin_s  = sync2_ff[3];
    assign vdd_uv_s   = sync2_ff[2];
    assign vpp_uv_s   = sync2_ff[1];

    // Parallel-mode decode
    rsc_gpio_map u_map (
        .MAP_SELECT   (map_s),
        .SEL_IN       (sel_s),
        .SWITCH_CLOSE (gpio_close)
    );

    // ---------------- Link domain ----------------

    // Frame idle while select_n high; clears bit position asynchronously
    assign frame_idle = SELECT_N || !NRST;

    // Incoming bits sampled on SCK rise
    always_ff @(posedge SCK or negedge NRST) begin
        if (!NRST) begin
            rx_ff <= 16'h0000;
        end else if (!SELECT_N) begin
            rx_ff <= {rx_ff[FRAME_BITS-2:0], MOSI};
        end
    end

    // Next outgoing bit position, saturating after one word
    always_comb begin
        nxt_idx = (idx_ff == IDX_SAT) ? idx_ff : idx_ff + 5'h01;
    end

    // Outgoing bit position and data, moved on SCK fall
    always_ff @(negedge SCK or posedge frame_idle) begin
        if (frame_idle) begin
            idx_ff  <= 5'h00;
            miso_ff <= 1'b0;
        end else begin
            idx_ff <= nxt_idx;
            if (nxt_idx < IDX_SAT) begin
                miso_ff <= tx_word_ff[4'hF - nxt_idx[3:0]];
            end else begin
                miso_ff <= rx_ff[FRAME_BITS-1];
            end
        end
    end

    // MSB shows before the first clock edge of the frame
    assign MISO_O  = (idx_ff == 5'h00) ? tx_word_ff[FRAME_BITS-1] : miso_ff;
    assign MISO_OE = !mode_par && !SELECT_N;

    // ---------------- System domain ----------------

    // Outgoing snapshot, frozen while a frame is open
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            tx_word_ff <= '0;
        end else if (CE && sel_n_s) begin
            tx_word_ff <= {ctrl_ff, state_ff};
        end
    end

    // Select edge history for the commit strobe
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            sel_n_d_ff <= 1'b1;
        end else if (CE) begin
            sel_n_d_ff <= sel_n_s;
        end
    end

    // Select rise seen in the system domain; SCK has stopped by now
    assign sel_rise = sel_n_s && !sel_n_d_ff;

    // Received word taken across once, while the link side is quiet
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            word_cap_ff  <= '0;
            cap_valid_ff <= 1'b0;
        end else if (CE) begin
            cap_valid_ff <= sel_rise && !mode_par;
            if (sel_rise) begin
                word_cap_ff <= rx_ff;
            end
        end
    end

    // Captured word commits when armed, serial mode only
    assign commit = cap_valid_ff && word_cap_ff[WORD_ARM_POS];

    // Fault sources, VPP watch depends on mode
    assign vpp_watch   = mode_par ? pump_pin_s : !ctrl_ff.pp_uv_cmp_off;
    assign fault_now   = vdd_uv_s || (vpp_uv_s && vpp_watch);
    assign shutdown_en = mode_par ? !fsd_pin_s : !ctrl_ff.fault_shutdown_off;
    assign pump_src    = mode_par ? pump_pin_s : ctrl_ff.pump_on;

    // Next register values from the committed word
    always_comb begin
        nxt_state = state_ff;
        nxt_ctrl  = ctrl_ff;
        if (commit) begin
            nxt_state = word_cap_ff[WORD_STATE_MSB:WORD_STATE_LSB];
            nxt_ctrl  = rsc_ctrl_t'(word_cap_ff[WORD_CTRL_MSB:WORD_CTRL_LSB]);
        end
        // A fault in the clearing cycle still sets the flag
        if (fault_now) begin
            nxt_ctrl.fault_sticky = 1'b1;
        end
    end

    // Switch state and control registers
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            state_ff <= STATE_RST;
            ctrl_ff  <= rsc_ctrl_t'(CTRL_RST);
        end else if (CE) begin
            state_ff <= nxt_state;
            ctrl_ff  <= nxt_ctrl;
        end
    end

    // Next shutdown step: a fault trips, pump source low then high restarts
    always_comb begin
        nxt_sd = sd_ff;
        unique case (sd_ff)
            SD_RUN: begin
                if (fault_now && shutdown_en) begin
                    nxt_sd = SD_TRIP;
                end
            end
            SD_TRIP: begin
                if (!pump_src && !(fault_now && shutdown_en)) begin
                    nxt_sd = SD_WAIT;
                end
            end
            SD_WAIT: begin
                if (fault_now && shutdown_en) begin
                    nxt_sd = SD_TRIP;
                end else if (pump_src) begin
                    nxt_sd = SD_RUN;
                end
            end
            default: begin
                nxt_sd = SD_TRIP;
            end
        endcase
    end

    // Shutdown state register; a stray code falls back to tripped
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            sd_ff <= SD_RUN;
        end else if (CE) begin
            sd_ff <= nxt_sd;
        end
    end

    // Switches and pump stay off until the restart toggle completes
    assign held_open = (sd_ff != SD_RUN);

    // Per-channel drive from mode, held open after a trip
    genvar gc;
    generate
        for (gc = 0; gc < CHANNELS; gc++) begin : g_chan
            assign SWITCH_CLOSE[gc] = !held_open
                && (mode_par ? gpio_close[gc] : state_ff[gc]);
        end
    endgenerate

    // Analog enables; spare control bits drive nothing
    assign PUMP_ENABLE    = pump_src && !held_open && ANALOG_ENABLE;
    assign ANALOG_ENABLE  = mode_par || !ctrl_ff.analog_off;
    assign VPP_CMP_ENABLE = vpp_watch;

    // Open-drain fault indicator follows the live fault
    assign FAULT_OUT_N_O  = 1'b0;
    assign FAULT_OUT_N_OE = fault_now;

    // Register views
    assign STATE_VIEW = state_ff;
    assign CTRL_VIEW  = ctrl_ff;

endmodule // rsc_top
`default_nettype wire

/* tb/rsc_top_asserts.sv */
// Concurrent checks on the relay switch control port pins
`timescale 1ns/10ps
`default_nettype none
module rsc_checker
    import rsc_pkg::*;
(
    input wire logic       CLK_SYS,        // System clock
    input wire logic       NRST,           // Reset, active low
    input wire logic       MODE,           // Mode pin
    input wire logic       SELECT_N,       // Frame select
    input wire logic       MISO_OE,        // Data out enable
    input wire logic       VDD_UV,         // Core supply low
    input wire logic       VPP_UV,         // High supply low
    input wire logic [5:0] SWITCH_CLOSE,   // Closures
    input wire logic       PUMP_ENABLE,    // Pump run
    input wire logic       ANALOG_ENABLE,  // Analog on
    input wire logic       VPP_CMP_ENABLE, // Comparator on
    input wire logic       FAULT_OUT_N_OE, // Fault pull-down
    input wire logic [7:0] STATE_VIEW,     // State register
    input wire logic [7:0] CTRL_VIEW       // Control register
);
    logic [3:0] hi_cnt_ff;  // Cycles select has stood high
    logic [3:0] ser_cnt_ff; // Cycles mode has stood low
    logic       ser;        // Serial mode settled
    // Saturating run-length counters
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            hi_cnt_ff  <= 4'h0;
            ser_cnt_ff <= 4'h0;
        end else begin
            hi_cnt_ff  <= !SELECT_N ? 4'h0 : hi_cnt_ff + {3'h0, hi_cnt_ff != 4'hF};
            ser_cnt_ff <= MODE ? 4'h0 : ser_cnt_ff + {3'h0, ser_cnt_ff != 4'hF};
        end
    end
    assign ser = ser_cnt_ff > 4'h3;
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!NRST);
    sequence s_uv_hold;
        VDD_UV [*3];
    endsequence
    sequence s_trip;
        (VDD_UV && ser && !CTRL_VIEW[CTRL_FSD_POS]) [*5];
    endsequence
    a_oe_idle: assert property (SELECT_N |-> !MISO_OE)
        else $error("data out driven outside a frame");
    a_oe_frame: assert property (ser && !SELECT_N |-> MISO_OE)
        else $error("data out not driven in a frame");
    a_sticky_set: assert property (s_uv_hold |-> ##[0:1] (CTRL_VIEW[6] && FAULT_OUT_N_OE))
        else $error("fault not flagged");
    a_sticky_hold: assert property (CTRL_VIEW[6] && hi_cnt_ff > 4'h5 |=> CTRL_VIEW[6])
        else $error("fault status dropped without a write");
    a_state_hold: assert property (hi_cnt_ff > 4'h5 |=> $stable(STATE_VIEW))
        else $error("state changed outside a commit");
    a_trip_open: assert property (s_trip |-> ##[0:1] (SWITCH_CLOSE == 6'h00 && !PUMP_ENABLE))
        else $error("fault did not open switches");
    a_pump_source: assert property (ser && PUMP_ENABLE |-> CTRL_VIEW[1] && ANALOG_ENABLE)
        else $error("pump runs without its bit");
    a_analog_bits: assert property (ser |-> ANALOG_ENABLE == !CTRL_VIEW[5]
        && (!ANALOG_ENABLE || VPP_CMP_ENABLE == !CTRL_VIEW[3]))
        else $error("analog or comparator enable wrong");
    a_switch_map: assert property (ser && CTRL_VIEW[4] && !CTRL_VIEW[5] && !CTRL_VIEW[6]
        && $stable(CTRL_VIEW) |-> SWITCH_CLOSE == STATE_VIEW[5:0])
        else $error("switches differ from state");
    a_fault_clear: assert property ((!VDD_UV && !VPP_UV) [*4] |-> !FAULT_OUT_N_OE)
        else $error("fault pin held after fault");
endmodule // rsc_checker
bind rsc_top rsc_checker rsc_checker_i (.CLK_SYS(CLK_SYS), .NRST(NRST), .MODE(MODE),
    .SELECT_N(SELECT_N), .MISO_OE(MISO_OE), .VDD_UV(VDD_UV), .VPP_UV(VPP_UV),
    .SWITCH_CLOSE(SWITCH_CLOSE), .PUMP_ENABLE(PUMP_ENABLE), .ANALOG_ENABLE(ANALOG_ENABLE),
    .VPP_CMP_ENABLE(VPP_CMP_ENABLE), .FAULT_OUT_N_OE(FAULT_OUT_N_OE),
    .STATE_VIEW(STATE_VIEW), .CTRL_VIEW(CTRL_VIEW));
`default_nettype wire

/* tb/rsc_host.sv */
// Serial host model that frames words on the link pins
`timescale 1ns/10ps
`default_nettype none
module rsc_host (
    output logic      sck,  // Link clock, still outside frames
    output logic      mosi, // Data to device
    output logic      ssn,  // Frame select, active low
    input  wire logic miso  // Data from device
);
    // Idle levels: clock low, data at its pull-down
    initial begin
        sck = 1'b0;
        mosi = 1'b0;
        ssn = 1'b0;
        #2;
        ssn = 1'b1;
    end
    // One frame of nbits, MSB first, one word per chained device
    task automatic xfer(input logic [31:0] tx, input int nbits, input int half,
                        output logic [31:0] rx);
        rx = 32'h0;
        ssn = 1'b0;
        #(half);
        for (int i = nbits - 1; i >= 0; i--) begin
            mosi = tx[i];
            #(half);
            sck = 1'b1;
            rx = {rx[30:0], miso};
            #(half);
            sck = 1'b0;
        end
        mosi = 1'b0;
        #(half);
        ssn = 1'b1;
    endtask
endmodule // rsc_host
`default_nettype wire

/* tb/relay_switch_control_port_test.sv */
// Self-checking bench for the relay switch control port
`timescale 1ns/10ps
`default_nettype none
module relay_switch_control_port_test;
    import rsc_pkg::*;
    logic clk_sys = 1'b0, nrst = 1'b0, mode = 1'b0, map_sel = 1'b0;
    logic pump_pin = 1'b0, fsd_pin = 1'b0, vdd_uv = 1'b0, vpp_uv = 1'b0;
    logic [3:0] par = 4'h0, pin;
    logic h_sck, h_mosi, h_ssn, miso_o, miso_oe, pump_en, ana_en, vpp_en, flt_o, flt_oe;
    logic [5:0] sw;
    logic [7:0] state_v, ctrl_v;
    logic [15:0] reg_exp = 16'h0000;
    logic held = 1'b0;
    int errors = 0, checked = 0;
    // Shared pins: parallel levels or link lines with the data-out pull-down
    assign pin = mode ? par : {h_ssn, miso_oe ? miso_o : 1'b0, h_mosi, h_sck};
    always #4 clk_sys = ~clk_sys;
    rsc_top rsc_top_i (.CLK_SYS(clk_sys), .NRST(nrst), .CE(1'b1), .MODE(mode), .SCK(pin[0]),
        .MOSI(pin[1]), .SELECT_N(pin[3]), .MISO_O(miso_o), .MISO_OE(miso_oe), .SEL_IN(pin),
        .MAP_SELECT(map_sel), .PUMP_ENABLE_PIN(pump_pin), .FAULT_SHUTDOWN_PIN(fsd_pin),
        .VDD_UV(vdd_uv), .VPP_UV(vpp_uv), .SWITCH_CLOSE(sw), .PUMP_ENABLE(pump_en),
        .ANALOG_ENABLE(ana_en), .VPP_CMP_ENABLE(vpp_en), .FAULT_OUT_N_O(flt_o),
        .FAULT_OUT_N_OE(flt_oe), .STATE_VIEW(state_v), .CTRL_VIEW(ctrl_v));
    rsc_host rsc_host_i (.sck(h_sck), .mosi(h_mosi), .ssn(h_ssn), .miso(pin[2]));
    // Compare and count
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic close_out;
        $display("Checks %0d, mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Expected parallel decode for {map, sel_in_4..1}
    function automatic logic [5:0] exp_par(input logic [4:0] v);
        logic [2:0] c;
        c = v[2:0];
        if (!v[4]) return {v[2], v[3], v[3], v[2], v[1], v[0]};
        if (c == 3'h0 || c == 3'h7) return 6'h00;
        if (!v[3]) return 6'h01 << (c - 3'h1);
        case (c)
            3'h1: return 6'h29;
            3'h2: return 6'h26;
            3'h3: return 6'h1A;
            3'h6: return 6'h15;
            default: return 6'h2A;
        endcase
    endfunction
    // One frame, then readback, register and output checks
    task automatic frame(input logic [31:0] tx, input int nbits, input int half);
        logic [31:0] rx;
        logic [31:0] exp_rx;
        exp_rx = (nbits == 16) ? {16'h0, reg_exp} : {reg_exp, tx[31:16]};
        rsc_host_i.xfer(tx, nbits, half, rx);
        chk("miso", rx, exp_rx);
        if (tx[15]) reg_exp = tx[15:0];
        cyc(6);
        chk("regs", {ctrl_v, state_v}, reg_exp);
        chk("analog", ana_en, !reg_exp[13]);
        if (!reg_exp[13]) chk("outs", {sw, pump_en, vpp_en}, {held ? 6'h00 : reg_exp[5:0], reg_exp[9] && !held, !reg_exp[11]});
    endtask
    initial begin
        #400000;
        errors++;
        close_out;
    end
    initial begin
        logic [15:0] w;
        logic [7:0] c;
        logic f, fsd;
        w = 16'($urandom(2));
        cyc(20);
        nrst = 1'b1;
        cyc(6);
        chk("reset", {ctrl_v, state_v}, 16'h0000);
        frame(32'h0, 16, 24);
        $display("Test reset done");
        for (int i = 0; i < 12; i++) begin
            w = 16'($urandom) & 16'hBF3F;
            pump_pin = 1'($urandom);
            fsd_pin = 1'($urandom);
            if (i % 3 == 2) frame({16'($urandom), w}, 32, 24);
            else frame({16'h0, w}, 16, 24);
        end
        $display("Test serial done");
        for (int k = 0; k < 4; k++) begin
            fsd = (k != 0);
            f = (k != 2);
            c = 8'h82 | {3'h0, fsd, 4'h0} | {4'h0, k == 2, 3'h0};
            frame({16'h0, c, 8'h3F}, 16, 24);
            if (k >= 2) vpp_uv = 1'b1;
            else vdd_uv = 1'b1;
            cyc(8);
            chk("fault", {flt_oe, ctrl_v[6], sw, pump_en}, {f, f, (f && !fsd) ? 6'h00 : 6'h3F, !(f && !fsd)});
            vdd_uv = 1'b0;
            vpp_uv = 1'b0;
            cyc(8);
            chk("latch", {flt_oe, ctrl_v[6]}, {1'b0, f});
            reg_exp[14] = f;
            held = f && !fsd;
            frame({16'h0, c & 8'hFD, 8'h3F}, 16, 24);
            held = 1'b0;
            frame({16'h0, c, 8'h3F}, 16, 24);
        end
        $display("Test fault done");
        mode = 1'b1;
        for (int i = 0; i < 32; i++) begin
            {map_sel, par} = 5'(i);
            cyc(4);
            chk("parallel", sw, exp_par(5'(i)));
        end
        $display("Test parallel done");
        close_out;
    end
endmodule // relay_switch_control_port_test
`default_nettype wire
